// ==== rtl/sls_regs.vh ====
// Notes on behaviour
// R1: mode 0 leaves supervisor idle, flag never set
// R2: mode 1 trips below low minus half hysteresis
// R3: mode 2 trips above high plus half hysteresis
// R4: mode 3 compares magnitude against low limit
// R5: mode 4 compares magnitude against high limit
// R6: mode 5 trips outside window, clears inside
// R7: status bit 5 shows sixth supervisor
// R8: status bits 0-4 show supervisors one-five
// R9: hold between thresholds; reset clears; upper bits zero
`ifndef SLS_REGS_VH
`define SLS_REGS_VH

// register bus geometry
`define SLS_ADDR_W 8
`define SLS_DATA_W 16
`define SLS_NUM_SUP 6

// global registers, byte addresses
`define SLS_STATUS_ADDR 8'h00
`define SLS_EVENT_ADDR 8'h04
`define SLS_DIV_ADDR 8'h08

// supervisor n (1..6) lives in the block whose upper nibble is n
`define SLS_SUP_FIRST 4'h1
`define SLS_SUP_LAST 4'h6
`define SLS_OFS_MODE 4'h0
`define SLS_OFS_LOW 4'h4
`define SLS_OFS_HIGH 4'h8
`define SLS_OFS_HYST 4'hc

// event register field positions
`define SLS_EV_RISE_LSB 0
`define SLS_EV_FALL_LSB 8

// comparison mode codes
`define SLS_MODE_W 3
`define SLS_MODE_DISABLED 3'h0
`define SLS_MODE_LOW 3'h1
`define SLS_MODE_HIGH 3'h2
`define SLS_MODE_ABS_LOW 3'h3
`define SLS_MODE_ABS_HIGH 3'h4
`define SLS_MODE_BOTH 3'h5

// reset values
`define SLS_RESET_MODE 3'h0
`define SLS_RESET_LIMIT 16'h0000
`define SLS_RESET_HYST 16'h0000
`define SLS_RESET_DIV 16'h0000

`endif

// ==== rtl/sls_cmp.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sls_regs.vh"

module sls_cmp (
    input wire i_clock,
    input wire i_rst,
    input wire i_tick,
    input wire [`SLS_MODE_W-1:0] i_mode,
    input wire signed [15:0] i_value,
    input wire signed [15:0] i_low,
    input wire signed [15:0] i_high,
    input wire [15:0] i_hyst,
    output reg o_active
);
    // widen to 18 bits so limit +/- half hysteresis never wraps
    wire signed [17:0] half = {3'b000, i_hyst[15:1]};
    wire signed [17:0] v = {{2{i_value[15]}}, i_value};
    wire signed [17:0] lo = {{2{i_low[15]}}, i_low};
    wire signed [17:0] hi = {{2{i_high[15]}}, i_high};
    wire signed [17:0] v_abs = v[17] ? -v : v;
    wire signed [17:0] lo_abs = lo[17] ? -lo : lo;
    wire signed [17:0] hi_abs = hi[17] ? -hi : hi;

    reg set_c;
    reg clr_c;
    reg active_nxt;

    // activation and deactivation thresholds per mode
    always @* begin
        set_c = 1'b0;
        clr_c = 1'b0;
        case (i_mode)
            `SLS_MODE_LOW: begin
                set_c = v < lo - half; // R2
                clr_c = v > lo + half; // R2
            end
            `SLS_MODE_HIGH: begin
                set_c = v > hi + half; // R3
                clr_c = v < hi - half; // R3
            end
            `SLS_MODE_ABS_LOW: begin
                set_c = v_abs < lo_abs - half; // R4
                clr_c = v_abs > lo_abs + half; // R4
            end
            `SLS_MODE_ABS_HIGH: begin
                set_c = v_abs > hi_abs + half; // R5
                clr_c = v_abs < hi_abs - half; // R5
            end
            `SLS_MODE_BOTH: begin
                set_c = (v > hi + half) || (v < lo - half); // R6
                clr_c = (v < hi - half) && (v > lo + half); // R6
            end
            default: begin
                set_c = 1'b0;
                clr_c = 1'b1; // R1
            end
        endcase
    end

    // set beats clear; otherwise hold inside the hysteresis band
    always @* begin
        if (set_c) begin
            active_nxt = 1'b1;
        end else if (clr_c) begin
            active_nxt = 1'b0;
        end else begin
            active_nxt = o_active; // R9
        end
    end

    // disabling takes effect at once, not on the next scan tick
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_active <= 1'b0; // R9
        end else if (i_mode == `SLS_MODE_DISABLED) begin
            o_active <= 1'b0; // R1
        end else if (i_tick) begin
            o_active <= active_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/sls_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sls_regs.vh"

module sls_top #(
    parameter NUM_SUP = `SLS_NUM_SUP
) (
    input wire i_clock,
    input wire i_rst,
    input wire [`SLS_ADDR_W-1:0] i_addr,
    input wire [`SLS_DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] i_signal_1,
    input wire [15:0] i_signal_2,
    input wire [15:0] i_signal_3,
    input wire [15:0] i_signal_4,
    input wire [15:0] i_signal_5,
    input wire [15:0] i_signal_6,
    output reg [`SLS_DATA_W-1:0] o_rdata,
    output wire [5:0] o_active
);
    // monitored values come from logic on this clock, so no synchroniser
    wire [16*6-1:0] sig_flat = {
        i_signal_6,
        i_signal_5,
        i_signal_4,
        i_signal_3,
        i_signal_2,
        i_signal_1
    };

    // address split into block number and offset within a block
    wire [3:0] blk = i_addr[7:4];
    wire [3:0] ofs = i_addr[3:0];
    wire sup_hit = (blk >= `SLS_SUP_FIRST) && (blk <= `SLS_SUP_LAST);
    wire [3:0] sup_idx = blk - `SLS_SUP_FIRST;

    // per-supervisor configuration storage
    reg [`SLS_MODE_W-1:0] mode_r [0:5];
    reg [15:0] low_r [0:5];
    reg [15:0] high_r [0:5];
    reg [15:0] hyst_r [0:5];

    // scan-rate divider state
    reg [15:0] div_r;
    reg [15:0] div_cnt_r;
    reg tick_r;

    // flag history and sticky change events
    reg [5:0] prev_r;
    reg [15:0] event_r;
    reg [15:0] event_nxt;

    // read path
    reg [`SLS_DATA_W-1:0] rdata_nxt;

    wire [5:0] active;

    // one comparator and one register set per supervisor
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_sup
            wire wr_here = i_wr && sup_hit && (sup_idx == g);

            // configuration writes for this supervisor
            always @(posedge i_clock) begin
                if (i_rst) begin
                    mode_r[g] <= `SLS_RESET_MODE; // R1
                    low_r[g] <= `SLS_RESET_LIMIT;
                    high_r[g] <= `SLS_RESET_LIMIT;
                    hyst_r[g] <= `SLS_RESET_HYST;
                end else if (wr_here) begin
                    case (ofs)
                        `SLS_OFS_MODE: begin
                            mode_r[g] <= i_wdata[`SLS_MODE_W-1:0];
                        end
                        `SLS_OFS_LOW: begin
                            low_r[g] <= i_wdata;
                        end
                        `SLS_OFS_HIGH: begin
                            high_r[g] <= i_wdata;
                        end
                        `SLS_OFS_HYST: begin
                            hyst_r[g] <= i_wdata;
                        end
                        default: begin
                            mode_r[g] <= mode_r[g];
                        end
                    endcase
                end
            end

            sls_cmp u_cmp (
                .i_clock(i_clock),
                .i_rst(i_rst),
                .i_tick(tick_r),
                .i_mode(mode_r[g]),
                .i_value(sig_flat[16*g +: 16]),
                .i_low(low_r[g]),
                .i_high(high_r[g]),
                .i_hyst(hyst_r[g]),
                .o_active(active[g])
            );
        end
    endgenerate

    // flags leave the comparators' own flip-flops; bits 0-4 then bit 5
    assign o_active = active; // R8 R7

    // scan tick: a divisor of zero evaluates every cycle
    // writing the divisor restarts the count so the new rate starts clean
    always @(posedge i_clock) begin
        if (i_rst) begin
            div_r <= `SLS_RESET_DIV;
            div_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            if (i_wr && (i_addr == `SLS_DIV_ADDR)) begin
                div_r <= i_wdata;
                div_cnt_r <= 16'h0000;
                tick_r <= 1'b0;
            end else if (div_cnt_r >= div_r) begin
                div_cnt_r <= 16'h0000;
                tick_r <= 1'b1;
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
                tick_r <= 1'b0;
            end
        end
    end

    // change events: a new edge in the clearing cycle survives
    always @* begin
        event_nxt = event_r;
        if (i_wr && (i_addr == `SLS_EVENT_ADDR)) begin
            event_nxt = event_r & ~i_wdata;
        end
        event_nxt[`SLS_EV_RISE_LSB +: 6] =
            event_nxt[`SLS_EV_RISE_LSB +: 6] | (active & ~prev_r);
        event_nxt[`SLS_EV_FALL_LSB +: 6] =
            event_nxt[`SLS_EV_FALL_LSB +: 6] | (~active & prev_r);
        event_nxt[7:6] = 2'b00;
        event_nxt[15:14] = 2'b00;
    end

    // edge history and event storage
    always @(posedge i_clock) begin
        if (i_rst) begin
            prev_r <= 6'b00_0000;
            event_r <= 16'h0000;
        end else begin
            prev_r <= active;
            event_r <= event_nxt;
        end
    end

    // read mux; unmapped addresses answer zero
    always @* begin
        rdata_nxt = 16'h0000;
        if (i_addr == `SLS_STATUS_ADDR) begin
            rdata_nxt = {10'b00_0000_0000, active}; // R8 R7 R9
        end else if (i_addr == `SLS_EVENT_ADDR) begin
            rdata_nxt = event_r;
        end else if (i_addr == `SLS_DIV_ADDR) begin
            rdata_nxt = div_r;
        end else if (sup_hit) begin
            case (ofs)
                `SLS_OFS_MODE: begin
                    rdata_nxt = {13'b0_0000_0000_0000, mode_r[sup_idx[2:0]]};
                end
                `SLS_OFS_LOW: begin
                    rdata_nxt = low_r[sup_idx[2:0]];
                end
                `SLS_OFS_HIGH: begin
                    rdata_nxt = high_r[sup_idx[2:0]];
                end
                `SLS_OFS_HYST: begin
                    rdata_nxt = hyst_r[sup_idx[2:0]];
                end
                default: begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ==== test/sls_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module sls_chk (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] i_signal_1,
    input wire logic [15:0] o_rdata,
    input wire logic [5:0] o_active
);
    reg [2:0] m1_r;
    reg signed [17:0] hi_r;
    reg signed [17:0] hf_r;
    reg [15:0] dv_r;
    // flag timing below only holds while every cycle is a scan tick
    wire dv_wr = i_wr && (i_addr == 8'h08);
    wire signed [17:0] sv = {{2{i_signal_1[15]}}, i_signal_1};
    // shadow of supervisor one, so its flag can be predicted from the bus
    always @(posedge i_clock) begin
        if (i_rst) begin
            m1_r <= 3'h0;
            hi_r <= 18'h0_0000;
            hf_r <= 18'h0_0000;
            dv_r <= 16'h0000;
        end else if (i_wr) begin
            if (i_addr == 8'h08) dv_r <= i_wdata;
            if (i_addr == 8'h10) m1_r <= i_wdata[2:0];
            if (i_addr == 8'h18) hi_r <= {{2{i_wdata[15]}}, i_wdata};
            if (i_addr == 8'h1c) hf_r <= {3'h0, i_wdata[15:1]}; // odd hysteresis truncates
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_reset_clear: assert property ($past(i_rst) |-> o_active == 6'h00)
        else $error("flags not clear after reset");
    a_status_read: assert property ($past(i_rd) && $past(i_addr) == 8'h00 && !$past(i_rst)
        |-> o_rdata == {10'h000, $past(o_active)}) else $error("status word wrong");
    a_upper_zero: assert property ($past(i_addr) == 8'h00 |-> o_rdata[15:6] == 10'h000)
        else $error("status upper bits set");
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_flag_hold: assert property (!$past(i_rst) && !$past(i_wr) && $stable(i_signal_1)
        && $past(dv_r) == 16'h0000
        |=> $stable(o_active[0])) else $error("flag moved on steady input");
    a_idle_clear: assert property (m1_r == 3'h0 |=> !o_active[0])
        else $error("disabled supervisor flagged");
    a_high_set: assert property (m1_r == 3'h2 && dv_r == 16'h0000 && !dv_wr
        && sv > hi_r + hf_r |=> o_active[0]) else $error("high trip missed");
    a_high_clear: assert property (m1_r == 3'h2 && dv_r == 16'h0000 && !dv_wr
        && sv < hi_r - hf_r |=> !o_active[0]) else $error("high release missed");
endmodule
bind sls_top sls_chk chk_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_signal_1(i_signal_1),
    .o_rdata(o_rdata), .o_active(o_active));
`default_nettype wire

// ==== test/sls_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sls_top_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] sig [6] = '{default: 16'h0000};
    logic [15:0] o_rdata;
    logic [5:0] o_active;
    int errors = 0;
    int checks = 0;
    sls_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_signal_1(sig[0]), .i_signal_2(sig[1]),
        .i_signal_3(sig[2]), .i_signal_4(sig[3]), .i_signal_5(sig[4]),
        .i_signal_6(sig[5]), .o_rdata(o_rdata), .o_active(o_active));
    // free-running clock, 25 ns period
    initial forever #12.5 i_clock = ~i_clock;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    // read data only stand in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task drive(input int k, input logic [15:0] v, input logic e);
        @(posedge i_clock);
        sig[k] <= v;
        repeat (2) @(posedge i_clock);
        #1 chk({15'h0000, o_active[k]}, {15'h0000, e});
    endtask
    // a trips, b sits between thresholds, c releases
    task run_mode(input int k, input logic [2:0] m, input logic [15:0] lo, hi, hy, a, b, c);
        logic [7:0] base;
        base = {k[3:0] + 4'h1, 4'h0};
        wr(base + 8'h04, lo);
        wr(base + 8'h08, hi);
        wr(base + 8'h0c, hy);
        wr(base, {13'h0000, m});
        drive(k, a, 1'b1);
        drive(k, b, 1'b1);
        drive(k, c, 1'b0);
        drive(k, b, 1'b0);
        drive(k, a, 1'b1);
        wr(base, 16'h0000);
        drive(k, a, 1'b0);
        drive(k, 16'h0000, 1'b0);
    endtask
    task t_reset;
        #1 chk({10'h000, o_active}, 16'h0000);
        rd(8'h00, 16'h0000);
        rd(8'hf0, 16'h0000);
        wr(8'h10, 16'hfff2);
        rd(8'h10, 16'h0002);
        wr(8'h10, 16'h0000);
        $display("t_reset done");
    endtask
    // equality with a threshold must hold, odd hysteresis halves down
    task t_modes;
        run_mode(0, 3'h2, 16'h0000, 16'h0064, 16'h0015, 16'h006f, 16'h006e, 16'h0059);
        run_mode(1, 3'h1, 16'hffce, 16'h0000, 16'h000a, 16'hffc8, 16'hffce, 16'hffd4);
        run_mode(2, 3'h3, 16'hffd8, 16'h0000, 16'h0008, 16'hffdd, 16'hffd8, 16'h002d);
        run_mode(3, 3'h4, 16'h0000, 16'hffd8, 16'h0008, 16'hffd3, 16'h0028, 16'h0023);
        run_mode(4, 3'h5, 16'hffec, 16'h0014, 16'h0004, 16'h0017, 16'h0015, 16'h0000);
        run_mode(5, 3'h5, 16'hffec, 16'h0014, 16'h0004, 16'hffe9, 16'hffeb, 16'h0000);
        $display("t_modes done");
    endtask
    // two flags at once, then a reset in mid-run wipes them
    task t_status;
        wr(8'h10, 16'h0002);
        wr(8'h60, 16'h0002);
        // limits left over from t_modes: high 100 and 20, so 112 trips both
        drive(0, 16'h0070, 1'b1);
        drive(5, 16'h0070, 1'b1);
        rd(8'h00, 16'h0021);
        @(posedge i_clock);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        rd(8'h00, 16'h0000);
        $display("t_status done");
    endtask
    // change events, a reserved mode code and a slow scan divisor
    task t_events;
        rd(8'h04, 16'h0000);
        wr(8'h10, 16'h0002);
        drive(0, 16'h0070, 1'b1);
        rd(8'h04, 16'h0001);
        wr(8'h04, 16'h0001);
        rd(8'h04, 16'h0000);
        wr(8'h10, 16'h0006);
        drive(0, 16'h0070, 1'b0);
        rd(8'h10, 16'h0006);
        rd(8'h04, 16'h0100);
        wr(8'h10, 16'h0002);
        drive(0, 16'hfff0, 1'b0);
        wr(8'h08, 16'h0003);
        sig[0] <= 16'h0070;
        repeat (3) @(posedge i_clock);
        #1 chk({15'h0000, o_active[0]}, 16'h0000);
        repeat (2) @(posedge i_clock);
        #1 chk({15'h0000, o_active[0]}, 16'h0001);
        rd(8'h08, 16'h0003);
        $display("t_events done");
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        t_modes();
        t_status();
        t_events();
        wrap_up();
    end
    // the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clock);
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
